// [hw/ccd_field_sequence_timing.sv]
`timescale 1ns/1ps
`include "ccd_seq_consts.svh"
module ccd_field_sequence_timing #(
	parameter int REGIONS = 9,
	parameter int MASK_PAIRS = 3,
	parameter int SLOTS = 7
) (
	// Pixel clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Sensor syncs, active low
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	// Register write port
	input wire logic reg_wr_in,
	input wire logic [11:0] reg_addr_in,
	input wire ccd_seq_pkg::word_t reg_wdata_in,
	// Timing pulses, active low
	output logic horizontal_blanking_out,
	output logic black_clamp_pulse_out,
	output logic input_preblanking_out,
	// Sequencer state
	output ccd_seq_pkg::group_t pattern_group_out,
	output ccd_seq_pkg::group_t field_group_out,
	output ccd_seq_pkg::group_t pattern_group_count_out,
	output logic [2:0] field_slot_out,
	output logic [3:0] region_out,
	output ccd_seq_pkg::line_t line_count_out,
	output ccd_seq_pkg::line_t pixel_count_out,
	output logic loading_out
);
	import ccd_seq_pkg::*;

	logic line_sync_prev_r;
	logic frame_sync_prev_r;
	logic line_edge;
	logic frame_edge;
	group_t pattern_group_count_r;
	logic [2:0] applied_field_count_r;
	group_t slot_r [SLOTS];
	logic mode_wr;
	logic mem_wr;
	logic [2:0] slot_idx_r;
	logic [2:0] slot_nxt;
	logic seq_started_r;
	group_t field_group_r;
	line_t line_r;
	line_t line_nxt;
	logic [3:0] region_r;
	logic [3:0] region_up;
	logic [3:0] dly_r;
	logic pend_r;
	logic cnt_zero;
	line_t hcount_r;
	logic line_start_r;
	seq_state_t state_r;
	logic [5:0] idx_r;
	logic rd_en;
	logic [10:0] rd_addr;
	word_t rd_data;
	logic cap_vld_r;
	logic cap_copy_r;
	logic [5:0] cap_idx_r;
	line_t scp_r [REGIONS];
	group_t hpsel_r [REGIONS];
	logic [7:0] psel_r [REGIONS];
	logic [8:0] cpol_r;
	logic [8:0] ppol_r;
	line_t cm_first_r [MASK_PAIRS];
	line_t cm_last_r [MASK_PAIRS];
	line_t pm_first_r [MASK_PAIRS];
	line_t pm_last_r [MASK_PAIRS];
	line_t tog_a_r [3];
	line_t tog_b_r [3];
	logic [3:0] clamp_pat;
	logic [3:0] preblank_pattern_choice;
	logic [MASK_PAIRS-1:0] cmask_hit;
	logic [MASK_PAIRS-1:0] pmask_hit;
	logic [2:0] pol_v;
	logic [2:0] mask_v;
	logic [2:0] pulse_v;
	logic busy_r;
	group_t pattern_group_r;

	// Falling edges of the syncs; inputs are already on this clock
	assign line_edge = line_sync_prev_r & ~line_sync_in;
	assign frame_edge = frame_sync_prev_r & ~frame_sync_in;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_sync_prev_r <= 1'b1;
			frame_sync_prev_r <= 1'b1;
		end else begin
			line_sync_prev_r <= line_sync_in;
			frame_sync_prev_r <= frame_sync_in;
		end
	end

	// Write decode: low half mode registers, high half pattern memory
	assign mode_wr = reg_wr_in & ~reg_addr_in[`MEM_SEL_BIT];
	assign mem_wr = reg_wr_in & reg_addr_in[`MEM_SEL_BIT];

	// Mode registers; writes take hold at once, the field sequence reads them at frame sync
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pattern_group_count_r <= '0;
			applied_field_count_r <= `RST_FIELD_COUNT;
			for (int s = 0; s < SLOTS; s++) begin
				slot_r[s] <= '0;
			end
		end else if (mode_wr) begin
			if (reg_addr_in == `ADDR_GROUP_COUNT) begin
				pattern_group_count_r <= reg_wdata_in[4:0];
			end
			if (reg_addr_in == `ADDR_FIELD_COUNT) begin
				applied_field_count_r <= reg_wdata_in[2:0];
			end
			for (int s = 0; s < SLOTS; s++) begin
				if (reg_addr_in == `ADDR_SLOT_BASE + 12'(s)) begin
					slot_r[s] <= reg_wdata_in[4:0];
				end
			end
		end
	end

	// Next slot; a count of zero behaves like one
	always_comb begin
		slot_nxt = 3'h0;
		if (seq_started_r && applied_field_count_r > 3'h1 &&
			slot_idx_r + 3'h1 < applied_field_count_r) begin
			slot_nxt = slot_idx_r + 3'h1;
		end
	end

	// Field sequence; first frame sync after reset lands on slot zero
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot_idx_r <= 3'h0;
			seq_started_r <= 1'b0;
			field_group_r <= '0;
		end else if (frame_edge) begin
			slot_idx_r <= slot_nxt;
			seq_started_r <= 1'b1;
			field_group_r <= slot_r[slot_nxt];
		end
	end

	// Line count and region walk
	assign line_nxt = line_r + 13'h1;
	assign region_up = region_r + 4'h1;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_r <= '0;
			region_r <= 4'h0;
		end else if (frame_edge) begin
			line_r <= '0;
			region_r <= 4'h0;
		end else if (line_edge) begin
			line_r <= line_nxt;
			if (region_r < 4'(REGIONS - 1) &&
				line_nxt == scp_r[region_up]) begin
				region_r <= region_up;
			end
		end
	end

	// Pipeline delay from line sync fall to counter zero
	assign cnt_zero = pend_r && (dly_r == `PIPE_LAST);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_r <= 1'b0;
			dly_r <= 4'h0;
		end else if (line_edge) begin
			pend_r <= 1'b1;
			dly_r <= 4'h1;
		end else if (cnt_zero) begin
			pend_r <= 1'b0;
			dly_r <= 4'h0;
		end else if (pend_r) begin
			dly_r <= dly_r + 4'h1;
		end
	end

	// Pixel counter; saturates so an absent line sync cannot wrap it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hcount_r <= '1;
			line_start_r <= 1'b0;
		end else begin
			line_start_r <= cnt_zero;
			if (cnt_zero) begin
				hcount_r <= '0;
			end else if (hcount_r != '1) begin
				hcount_r <= hcount_r + 13'h1;
			end
		end
	end

	// Loader: copy the field record at frame sync, fetch toggles per line.
	// The copy runs past the first lines, so frame sync should sit in
	// vertical blanking; the four-word fetch fits inside the delay.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= SEQ_IDLE;
			idx_r <= 6'h0;
		end else if (frame_edge) begin
			state_r <= SEQ_COPY;
			idx_r <= 6'h0;
		end else begin
			unique case (state_r)
				SEQ_IDLE: begin
					if (line_edge) begin
						state_r <= SEQ_FETCH;
						idx_r <= 6'h0;
					end
				end
				SEQ_COPY: begin
					idx_r <= idx_r + 6'h1;
					if (idx_r == `W_LAST) begin
						state_r <= SEQ_FETCH;
						idx_r <= 6'h0;
					end
				end
				SEQ_FETCH: begin
					idx_r <= idx_r + 6'h1;
					if (line_edge) begin
						idx_r <= 6'h0;
					end else if (idx_r[1:0] == `FETCH_LAST) begin
						state_r <= SEQ_IDLE;
					end
				end
			endcase
		end
	end

	// Pattern choices of the current region
	assign clamp_pat = psel_r[region_r][3:0];
	assign preblank_pattern_choice = psel_r[region_r][7:4];

	// Read address: record words, or toggle pairs of chosen patterns
	always_comb begin
		rd_en = (state_r != SEQ_IDLE);
		rd_addr = 11'h0;
		unique case (state_r)
			SEQ_IDLE: rd_addr = 11'h0;
			SEQ_COPY: rd_addr = {field_group_r, idx_r};
			SEQ_FETCH: begin
				if (idx_r[1]) begin
					rd_addr = {`TOGGLE_PAGE,
						`T_INPUT_PREBLANKING + {1'b0, preblank_pattern_choice, idx_r[0]}};
				end else begin
					rd_addr = {`TOGGLE_PAGE,
						`T_CLAMP + {1'b0, clamp_pat, idx_r[0]}};
				end
			end
		endcase
	end

	ccd_seq_mem #(
		.DW(16),
		.AW(11)
	) u_mem (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(mem_wr),
		.wr_addr_in(reg_addr_in[10:0]),
		.wr_data_in(reg_wdata_in),
		.rd_en_in(rd_en),
		.rd_addr_in(rd_addr),
		.rd_data_out(rd_data)
	);

	// Read data arrives a cycle later; remember what was asked
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cap_vld_r <= 1'b0;
			cap_copy_r <= 1'b0;
			cap_idx_r <= 6'h0;
		end else begin
			cap_vld_r <= rd_en;
			cap_copy_r <= (state_r == SEQ_COPY);
			cap_idx_r <= idx_r;
		end
	end

	// Active field record
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cpol_r <= `RST_POL;
			ppol_r <= `RST_POL;
			for (int r = 0; r < REGIONS; r++) begin
				scp_r[r] <= '0;
				hpsel_r[r] <= '0;
				psel_r[r] <= 8'h0;
			end
			for (int m = 0; m < MASK_PAIRS; m++) begin
				cm_first_r[m] <= `RST_MASK_FIRST;
				cm_last_r[m] <= `RST_MASK_LAST;
				pm_first_r[m] <= `RST_MASK_FIRST;
				pm_last_r[m] <= `RST_MASK_LAST;
			end
		end else if (cap_vld_r && cap_copy_r) begin
			for (int r = 0; r < REGIONS; r++) begin
				if (cap_idx_r == `W_SCP + 6'(r))
					scp_r[r] <= rd_data[12:0];
				if (cap_idx_r == `W_HPSEL + 6'(r))
					hpsel_r[r] <= rd_data[4:0];
				if (cap_idx_r == `W_PSEL + 6'(r))
					psel_r[r] <= rd_data[7:0];
			end
			if (cap_idx_r == `W_CPOL)
				cpol_r <= rd_data[8:0];
			if (cap_idx_r == `W_PPOL)
				ppol_r <= rd_data[8:0];
			for (int m = 0; m < MASK_PAIRS; m++) begin
				if (cap_idx_r == `W_CMASK + 6'(2 * m))
					cm_first_r[m] <= rd_data[12:0];
				if (cap_idx_r == `W_CMASK + 6'(2 * m + 1))
					cm_last_r[m] <= rd_data[12:0];
				if (cap_idx_r == `W_PMASK + 6'(2 * m))
					pm_first_r[m] <= rd_data[12:0];
				if (cap_idx_r == `W_PMASK + 6'(2 * m + 1))
					pm_last_r[m] <= rd_data[12:0];
			end
		end
	end

	// Toggle pairs: 0 blanking from the record, 1 clamp, 2 preblank
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int k = 0; k < 3; k++) begin
				tog_a_r[k] <= `RST_TOG;
				tog_b_r[k] <= `RST_TOG;
			end
		end else if (cap_vld_r && cap_copy_r) begin
			if (cap_idx_r == `W_HTOG)
				tog_a_r[0] <= rd_data[12:0];
			if (cap_idx_r == `W_LAST)
				tog_b_r[0] <= rd_data[12:0];
		end else if (cap_vld_r) begin
			unique case (cap_idx_r[1:0])
				2'h0: tog_a_r[1] <= rd_data[12:0];
				2'h1: tog_b_r[1] <= rd_data[12:0];
				2'h2: tog_a_r[2] <= rd_data[12:0];
				2'h3: tog_b_r[2] <= rd_data[12:0];
			endcase
		end
	end

	// Inclusive line mask ranges; first above last disables a pair
	for (genvar g = 0; g < MASK_PAIRS; g++) begin : g_mask
		assign cmask_hit[g] = (line_r >= cm_first_r[g]) &&
			(line_r <= cm_last_r[g]);
		assign pmask_hit[g] = (line_r >= pm_first_r[g]) &&
			(line_r <= pm_last_r[g]);
	end

	// Start levels and masks per pulse; blanking starts inactive
	assign pol_v = {ppol_r[region_r], cpol_r[region_r], 1'b1};
	assign mask_v = {|pmask_hit, |cmask_hit, 1'b0};

	for (genvar k = 0; k < 3; k++) begin : g_pulse
		ccd_pulse_gen #(
			.W(13)
		) u_pulse (
			.clk_in(clk_in),
			.rst_n_in(rst_n_in),
			.count_in(hcount_r),
			.tog_a_in(tog_a_r[k]),
			.tog_b_in(tog_b_r[k]),
			.line_start_in(line_start_r),
			.start_level_in(pol_v[k]),
			.mask_in(mask_v[k]),
			.pulse_out(pulse_v[k])
		);
	end

	// Region pattern group and loader busy flag
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pattern_group_r <= '0;
			busy_r <= 1'b0;
		end else begin
			pattern_group_r <= hpsel_r[region_r];
			busy_r <= rd_en;
		end
	end

	// Outputs, each from a flip-flop
	assign horizontal_blanking_out = pulse_v[0];
	assign black_clamp_pulse_out = pulse_v[1];
	assign input_preblanking_out = pulse_v[2];
	assign pattern_group_out = pattern_group_r;
	assign field_group_out = field_group_r;
	assign pattern_group_count_out = pattern_group_count_r;
	assign field_slot_out = slot_idx_r;
	assign region_out = region_r;
	assign line_count_out = line_r;
	assign pixel_count_out = hcount_r;
	assign loading_out = busy_r;
endmodule

// [hw/ccd_pulse_gen.sv]
`timescale 1ns/1ps
module ccd_pulse_gen #(
	parameter int W = 13
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Position and toggle points
	input wire logic [W-1:0] count_in,
	input wire logic [W-1:0] tog_a_in,
	input wire logic [W-1:0] tog_b_in,
	// Line control
	input wire logic line_start_in,
	input wire logic start_level_in,
	input wire logic mask_in,
	// Pulse
	output logic pulse_out
);
	logic phase_r;
	logic phase_nxt;
	logic hit;

	// Toggle on either point; line start reloads the start level
	always_comb begin
		hit = (count_in == tog_a_in) || (count_in == tog_b_in);
		phase_nxt = phase_r;
		if (line_start_in) begin
			phase_nxt = start_level_in;
		end else if (hit) begin
			phase_nxt = ~phase_r;
		end
	end

	// Phase keeps running under a mask so unmasked lines stay intact
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_r <= 1'b1;
			pulse_out <= 1'b1;
		end else begin
			phase_r <= phase_nxt;
			pulse_out <= mask_in ? 1'b1 : phase_nxt;
		end
	end
endmodule

// [hw/ccd_seq_mem.sv]
`timescale 1ns/1ps
module ccd_seq_mem #(
	parameter int DW = 16,
	parameter int AW = 11
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Write port
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [DW-1:0] wr_data_in,
	// Read port
	input wire logic rd_en_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [DW-1:0] rd_data_out
);
	logic [DW-1:0] mem_r [2**AW];

	// Storage has no reset; software loads it at startup
	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
	end

	// Registered read, one cycle after the address
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= '0;
		end else if (rd_en_in) begin
			rd_data_out <= mem_r[rd_addr_in];
		end
	end
endmodule

// [shared/ccd_seq_consts.svh]
`ifndef CCD_SEQ_CONSTS_SVH
`define CCD_SEQ_CONSTS_SVH

// Pixel clocks from line sync fall to pixel counter zero
`define PIPE_DELAY 4'd12
`define PIPE_LAST (`PIPE_DELAY - 4'd1)

// Write address map: bit 11 set selects the pattern memory at 0x800
`define MEM_SEL_BIT 11
`define ADDR_GROUP_COUNT 12'h000
`define ADDR_FIELD_COUNT 12'h001
`define ADDR_SLOT_BASE 12'h008

// Field group record, word index inside a 64-word group page
`define W_SCP 6'd0
`define W_HPSEL 6'd9
`define W_CPOL 6'd18
`define W_PPOL 6'd19
`define W_PSEL 6'd20
`define W_CMASK 6'd29
`define W_PMASK 6'd35
`define W_HTOG 6'd41
`define W_LAST 6'd42

// Toggle page holds clamp and preblank pattern toggle pairs
`define TOGGLE_PAGE 5'h1f
`define T_CLAMP 6'd0
`define T_INPUT_PREBLANKING 6'd20
`define FETCH_LAST 2'd3

// Reset values
`define RST_FIELD_COUNT 3'h1
`define RST_POL 9'h1ff
`define RST_TOG 13'h1fff
`define RST_MASK_FIRST 13'h1fff
`define RST_MASK_LAST 13'h0000

`endif

// [shared/ccd_seq_pkg.sv]
package ccd_seq_pkg;
	typedef logic [12:0] line_t;
	typedef logic [4:0] group_t;
	typedef logic [15:0] word_t;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_COPY, SEQ_FETCH} seq_state_t;
endpackage

// [testbench/ccd_sensor_model.sv]
`timescale 1ns/1ps
module ccd_sensor_model (
	// Pixel clock
	input wire logic clk_in,
	// Syncs, active low
	output logic line_sync_n_out,
	output logic frame_sync_n_out
);
	// Syncs idle high from time zero
	initial begin
		line_sync_n_out = 1'b1;
		frame_sync_n_out = 1'b1;
	end
	// Four-clock low pulse; only the fall matters to the sequencer
	task automatic pulse(input bit frame);
		@(posedge clk_in);
		if (frame)
			frame_sync_n_out <= 1'b0;
		else
			line_sync_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		frame_sync_n_out <= 1'b1;
		line_sync_n_out <= 1'b1;
	endtask
endmodule

// [testbench/ccd_seq_assertions.sv]
`timescale 1ns/1ps
module ccd_seq_checker (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Syncs
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	// Observed outputs
	input wire logic horizontal_blanking_out,
	input wire ccd_seq_pkg::group_t field_group_out,
	input wire logic [2:0] field_slot_out,
	input wire logic [3:0] region_out,
	input wire ccd_seq_pkg::line_t line_count_out,
	input wire ccd_seq_pkg::line_t pixel_count_out
);
	import ccd_seq_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Sync edges are sampled falls of the active-low inputs
	AST_PIX_ZERO: assert property ($fell(line_sync_in) |-> ##12 pixel_count_out == 13'h0000)
		else $error("pixel counter not zero twelve clocks after line sync");
	AST_PIX_RUN: assert property (pixel_count_out == 13'h0000 |=> pixel_count_out == 13'h0001 ##1 pixel_count_out == 13'h0002)
		else $error("pixel counter does not advance once per clock");
	AST_HB_START: assert property (pixel_count_out == 13'h0000 |=> horizontal_blanking_out)
		else $error("blanking not at its start level after counter zero");
	AST_FRAME_LINE: assert property ($fell(frame_sync_in) |=> line_count_out == 13'h0000 && region_out == 4'h0)
		else $error("frame sync did not restart lines and regions");
	AST_LINE_INC: assert property ($fell(line_sync_in) && !$fell(frame_sync_in) |=> line_count_out == $past(line_count_out) + 13'h0001)
		else $error("line count did not step on line sync");
	AST_REGION_HOLD: assert property (!$fell(line_sync_in) && !$fell(frame_sync_in) |=> $stable(region_out))
		else $error("region changed without a sync edge");
	AST_REGION_STEP: assert property ($fell(line_sync_in) && !$fell(frame_sync_in) |=> region_out == $past(region_out) || region_out == $past(region_out) + 4'h1)
		else $error("region moved by more than one");
	AST_SLOT_HOLD: assert property (!$fell(frame_sync_in) |=> $stable(field_slot_out) && $stable(field_group_out))
		else $error("field selection changed outside frame sync");
	AST_SLOT_RANGE: assert property (field_slot_out <= 3'h6)
		else $error("field slot beyond seventh");
endmodule

bind ccd_field_sequence_timing ccd_seq_checker checker_i (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.line_sync_in(line_sync_in),
	.frame_sync_in(frame_sync_in),
	.horizontal_blanking_out(horizontal_blanking_out),
	.field_group_out(field_group_out),
	.field_slot_out(field_slot_out),
	.region_out(region_out),
	.line_count_out(line_count_out),
	.pixel_count_out(pixel_count_out)
);

// [testbench/tb_ccd_field_sequence_timing.sv]
`timescale 1ns/1ps
module tb_ccd_field_sequence_timing;
	import ccd_seq_pkg::*;
	logic clk_in, rst_n_in, reg_wr_in, line_sync_n, frame_sync_n;
	logic [11:0] reg_addr_in;
	word_t reg_wdata_in;
	logic horizontal_blanking_out, black_clamp_pulse_out;
	logic input_preblanking_out, loading_out;
	group_t pattern_group_out, field_group_out, pattern_group_count_out;
	logic [2:0] field_slot_out;
	logic [3:0] region_out;
	line_t line_count_out, pixel_count_out;
	logic [4:0] cexp, bexp;
	int bad_count = 0;
	int n_compared = 0;
	// Address in high twelve bits, data in low sixteen
	// Field groups in use and the toggle page; cleared before loading
	group_t clr_g [4] = '{5'd2, 5'd3, 5'd4, 5'd31};
	logic [27:0] prog [23] = '{28'h8810003, 28'h8890004, 28'h88a0007,
		28'h8920001, 28'h89301ff, 28'h8940010, 28'h8950011, 28'h89d0005,
		28'h89e0005, 28'h8a30003, 28'h8a40004, 28'h8c90009, 28'h909000b,
		28'hfc00058, 28'hfc1006c, 28'hfc20030, 28'hfc30044, 28'hfd6008a,
		28'hfd70094, 28'h0010003, 28'h0080002, 28'h0090003, 28'h00a0004};
	line_t pts [5] = '{13'd40, 13'd58, 13'd98, 13'd120, 13'd143};
	group_t fg [5] = '{5'd3, 5'd4, 5'd2, 5'd2, 5'd4};
	logic [2:0] sl [5] = '{3'd1, 3'd2, 3'd0, 3'd0, 3'd0};
	group_t pg [5] = '{5'd9, 5'd11, 5'd4, 5'd4, 5'd11};

	ccd_field_sequence_timing dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.line_sync_in(line_sync_n), .frame_sync_in(frame_sync_n),
		.reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.horizontal_blanking_out(horizontal_blanking_out),
		.black_clamp_pulse_out(black_clamp_pulse_out),
		.input_preblanking_out(input_preblanking_out),
		.pattern_group_out(pattern_group_out),
		.field_group_out(field_group_out),
		.pattern_group_count_out(pattern_group_count_out),
		.field_slot_out(field_slot_out), .region_out(region_out),
		.line_count_out(line_count_out),
		.pixel_count_out(pixel_count_out), .loading_out(loading_out));

	ccd_sensor_model sens (.clk_in(clk_in), .line_sync_n_out(line_sync_n),
		.frame_sync_n_out(frame_sync_n));

	// 200 MHz pixel clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe, taken at the following edge
	task automatic wr(input logic [11:0] a, input word_t d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	// Bounded wait for a pixel position; a hang ends the run
	task automatic wait_pix(input line_t p);
		int i;
		for (i = 0; i < 400 && pixel_count_out !== p; i++)
			@(posedge clk_in);
		if (pixel_count_out !== p) begin
			bad_count++;
			$display("[ERR] %0t pixel wait ran out", $time);
			conclude();
		end
	endtask

	// Main sequence: reset, program, walk a field, then chain fields
	initial begin
		rst_n_in = 1'b0;
		reg_wr_in = 1'b0;
		reg_addr_in = 12'h000;
		reg_wdata_in = 16'h0000;
		repeat (6) @(posedge clk_in);
		chk(pixel_count_out, 13'h1fff);
		chk(black_clamp_pulse_out, 1'b1);
		chk(field_slot_out, 3'h0);
		rst_n_in <= 1'b1;
		wr(12'h000, 16'h0005);
		wr(12'h002, 16'h0009);
		chk(pattern_group_count_out, 5'h05);
		// Pattern memory has no reset; unwritten words would read unknown
		for (int c = 0; c < 4; c++)
			for (int w = 0; w < 43; w++)
				wr({1'b1, clr_g[c], 6'(w)}, 16'h0000);
		// Toggles loaded as the wanted pixel counter positions, none near zero
		for (int n = 0; n < 23; n++)
			wr(prog[n][27:16], prog[n][15:0]);
		sens.pulse(1'b1);
		repeat (80) @(posedge clk_in);
		chk(loading_out, 1'b0);
		chk(field_group_out, 5'h02);
		chk(field_slot_out, 3'h0);
		// Clamp and preblank never active together in this layout
		for (int k = 1; k <= 5; k++) begin
			cexp = (k == 5) ? 5'h1f : (k >= 3) ? 5'h02 : 5'h1b;
			bexp = (k == 3 || k == 4) ? 5'h1f : 5'h0f;
			sens.pulse(1'b0);
			@(posedge clk_in);
			chk(line_count_out, 13'(k));
			chk(loading_out, 1'b1);
			for (int j = 0; j < 5; j++) begin
				wait_pix(pts[j]);
				chk(black_clamp_pulse_out, cexp[j]);
				chk(input_preblanking_out, bexp[j]);
			end
			chk(region_out, (k >= 3) ? 4'h1 : 4'h0);
			chk(pattern_group_out, (k >= 3) ? 5'h07 : 5'h04);
			chk(horizontal_blanking_out, 1'b1);
		end
		// Field chain wraps at count three, then single field mode
		for (int f = 0; f < 5; f++) begin
			if (f == 3)
				wr(12'h001, 16'h0001);
			if (f == 4)
				wr(12'h008, 16'h0004);
			sens.pulse(1'b1);
			repeat (80) @(posedge clk_in);
			sens.pulse(1'b0);
			repeat (30) @(posedge clk_in);
			chk(field_group_out, fg[f]);
			chk(field_slot_out, sl[f]);
			chk(pattern_group_out, pg[f]);
		end
		conclude();
	end
endmodule
